// *** hdl/irs_exception_unit.sv ***
// Interrupt recognition, priority, stacking and return logic of the CPU
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module irs_exception_unit
    import irs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic [NUM_SRC-1:1] eventSet,
    input wire logic irqPinN,
    input wire logic xirqPinN,
    input wire logic instrBoundary,
    input wire logic illegalOp,
    input wire logic swiExec,
    input wire logic rtiExec,
    input wire logic [15:0] opAddr,
    input wire logic [15:0] pcIn,
    input wire logic [15:0] iyIn,
    input wire logic [15:0] ixIn,
    input wire logic [7:0] accAIn,
    input wire logic [7:0] accBIn,
    input wire logic [7:0] ccrIn,
    input wire logic [15:0] spIn,
    input wire logic [7:0] stackRdData,
    output logic [15:0] stackAddr,
    output logic [7:0] stackWrData,
    output logic stackWrite,
    output logic stackRead,
    output logic [15:0] vectorAddr,
    output logic vectorValid,
    output logic busy,
    output logic globalIrqMask,
    output logic nonmaskableMask,
    output logic restoreValid,
    output logic [3:0] restoreSel,
    output logic [7:0] restoreData
);
    typedef struct packed {
        logic waitReq;
        logic [31:0] rdData;
        logic [PSEL_W-1:0] psel;
        logic visBit;
        logic maskI;
        logic maskX;
        logic [NUM_SRC-1:1] flags;
        logic [NUM_SRC-1:1] enables;
        irs_state_type state;
        irs_kind_type kind;
        logic [3:0] cnt;
        logic [3:0] entryIdx;
        logic [15:0] pcSave;
        logic [15:0] iySave;
        logic [15:0] ixSave;
        logic [7:0] aSave;
        logic [7:0] bSave;
        logic [7:0] ccrSave;
        logic [15:0] spBase;
        logic [15:0] stkAddr;
        logic [7:0] stkData;
        logic stkWr;
        logic stkRd;
        logic [15:0] vecAddr;
        logic vecValid;
        logic pullValid;
        logic [3:0] pullIdx;
        logic rstValid;
        logic [3:0] rstSel;
        logic [7:0] rstData;
        logic [4:0] lastSrc;
        logic busyFlag;
    } irs_regs_type;

    irs_regs_type cur_ff;
    irs_regs_type nxt_cur;

    // Source index chosen by a promote code
    function automatic logic [3:0] promoteIndex(input logic [3:0] code);
        logic [3:0] idx;
        idx = SRC_IRQ;
        unique case (code)
            PSEL_TOF: idx = SRC_TOF;
            PSEL_PAOV: idx = SRC_PAOV;
            PSEL_PAEDGE: idx = SRC_PAEDGE;
            PSEL_SPI: idx = SRC_SPI;
            PSEL_SCI: idx = SRC_SCI;
            PSEL_RSVD, PSEL_IRQ: idx = SRC_IRQ;
            PSEL_RTI: idx = SRC_RTI;
            default: begin
                if (code < PSEL_OC1) begin
                    idx = 4'(code - PSEL_IC1 + SRC_IC1);
                end else if (code < PSEL_IC4OC5) begin
                    idx = 4'(code - PSEL_OC1 + SRC_OC1);
                end else begin
                    idx = SRC_IC4OC5;
                end
            end
        endcase
        return idx;
    endfunction : promoteIndex

    // Frame byte for a push step, PC low first
    function automatic logic [7:0] frameByte(input irs_regs_type r, input logic [3:0] step);
        logic [7:0] b;
        b = r.ccrSave;
        unique case (step)
            4'h0: b = r.pcSave[7:0];
            4'h1: b = r.pcSave[15:8];
            4'h2: b = r.iySave[7:0];
            4'h3: b = r.iySave[15:8];
            4'h4: b = r.ixSave[7:0];
            4'h5: b = r.ixSave[15:8];
            4'h6: b = r.aSave;
            4'h7: b = r.bSave;
            default: b = r.ccrSave;
        endcase
        return b;
    endfunction : frameByte

    logic [NUM_SRC-1:0] maskReq;
    logic anyMask;
    logic [3:0] winIdx;
    logic [3:0] promIdx;
    logic xirqReq;
    logic busRd;
    logic busWr;
    logic [NUM_SRC-1:1] laneMask;
    logic [NUM_SRC-1:1] wFlagClr;

    always_comb begin
        maskReq[SRC_IRQ] = ~irqPinN & ~cur_ff.maskI;
        maskReq[NUM_SRC-1:1] = cur_ff.flags & cur_ff.enables & {(NUM_SRC-1){~cur_ff.maskI}};
        anyMask = |maskReq;
        xirqReq = ~xirqPinN & ~cur_ff.maskX;
        promIdx = promoteIndex(cur_ff.psel);
        winIdx = SRC_SCI;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (maskReq[i]) begin
                winIdx = 4'(i);
            end
        end
        if (maskReq[promIdx]) begin
            winIdx = promIdx;
        end
        busRd = avsRead & cur_ff.waitReq;
        busWr = avsWrite & ~cur_ff.waitReq;
        laneMask = {{7{avsByteEnable[1]}}, {7{avsByteEnable[0]}}};
        wFlagClr = '0;
        if (busWr && avsAddress == ADDR_W'(OFS_FLAG)) begin
            wFlagClr = avsWriteData[NUM_SRC-1:1] & laneMask;
        end
    end

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.stkWr = 1'b0;
        nxt_cur.stkRd = 1'b0;
        nxt_cur.vecValid = 1'b0;
        nxt_cur.rstValid = 1'b0;
        nxt_cur.pullValid = 1'b0;
        // Bus slave: one wait cycle, write lands at the accepting edge
        nxt_cur.waitReq = ~((avsRead | avsWrite) & cur_ff.waitReq);
        if (busRd) begin
            unique case (avsAddress)
                ADDR_W'(OFS_PRIO): nxt_cur.rdData = {27'h0, cur_ff.visBit, cur_ff.psel};
                ADDR_W'(OFS_MASK): nxt_cur.rdData = {30'h0, cur_ff.maskX, cur_ff.maskI};
                ADDR_W'(OFS_FLAG): nxt_cur.rdData = {17'h0, cur_ff.flags, ~irqPinN};
                ADDR_W'(OFS_ENAB): nxt_cur.rdData = {17'h0, cur_ff.enables, 1'b0};
                ADDR_W'(OFS_STAT): nxt_cur.rdData = {16'h0, 5'h0, cur_ff.state, 3'h0, cur_ff.lastSrc};
                default: nxt_cur.rdData = 32'h0000_0000;
            endcase
        end
        if (busWr && avsByteEnable[0]) begin
            if (avsAddress == ADDR_W'(OFS_PRIO)) begin
                nxt_cur.visBit = avsWriteData[VIS_BIT];
                if (cur_ff.maskI) begin
                    nxt_cur.psel = avsWriteData[PSEL_LSB +: PSEL_W];
                end
            end
            if (avsAddress == ADDR_W'(OFS_MASK)) begin
                nxt_cur.maskI = avsWriteData[MASK_I_BIT];
                nxt_cur.maskX = cur_ff.maskX & avsWriteData[MASK_X_BIT];
            end
        end
        if (busWr && avsAddress == ADDR_W'(OFS_ENAB)) begin
            nxt_cur.enables = (cur_ff.enables & ~laneMask) | (avsWriteData[NUM_SRC-1:1] & laneMask);
        end
        // Set wins over a simultaneous clear
        nxt_cur.flags = (cur_ff.flags & ~wFlagClr) | eventSet;

        unique case (cur_ff.state)
            ST_IDLE: begin
                nxt_cur.cnt = '0;
                nxt_cur.pcSave = pcIn;
                nxt_cur.iySave = iyIn;
                nxt_cur.ixSave = ixIn;
                nxt_cur.aSave = accAIn;
                nxt_cur.bSave = accBIn;
                nxt_cur.ccrSave = ccrIn;
                nxt_cur.ccrSave[CCR_X_BIT] = cur_ff.maskX;
                nxt_cur.ccrSave[CCR_I_BIT] = cur_ff.maskI;
                nxt_cur.spBase = spIn;
                nxt_cur.entryIdx = winIdx;
                if (instrBoundary) begin
                    if (illegalOp) begin
                        nxt_cur.kind = K_ILL;
                        nxt_cur.pcSave = opAddr;
                        nxt_cur.state = ST_PUSH;
                    end else if (swiExec) begin
                        nxt_cur.kind = K_SWI;
                        nxt_cur.state = ST_PUSH;
                    end else if (rtiExec) begin
                        nxt_cur.state = ST_PULL;
                    end else if (xirqReq) begin
                        nxt_cur.kind = K_NONMASKABLE_PIN;
                        nxt_cur.state = ST_PUSH;
                    end else if (anyMask) begin
                        nxt_cur.kind = K_MASK;
                        nxt_cur.state = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                nxt_cur.stkWr = 1'b1;
                nxt_cur.stkAddr = 16'(cur_ff.spBase - 16'(cur_ff.cnt));
                nxt_cur.stkData = frameByte(cur_ff, cur_ff.cnt);
                nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
                if (cur_ff.cnt == FRAME_LAST) begin
                    nxt_cur.state = ST_VECTOR;
                end
            end
            ST_VECTOR: begin
                // Masks move only once the condition code byte is in memory
                nxt_cur.vecValid = 1'b1;
                nxt_cur.state = ST_IDLE;
                nxt_cur.maskI = 1'b1;
                if (cur_ff.kind == K_ILL) begin
                    nxt_cur.vecAddr = VEC_ILL;
                    nxt_cur.lastSrc = 5'h12;
                end else if (cur_ff.kind == K_SWI) begin
                    nxt_cur.vecAddr = VEC_SWI;
                    nxt_cur.lastSrc = 5'h11;
                end else if (xirqReq) begin
                    nxt_cur.maskX = 1'b1;
                    nxt_cur.vecAddr = VEC_NONMASKABLE_PIN;
                    nxt_cur.lastSrc = 5'h10;
                end else begin
                    // Vector tied to source index only
                    nxt_cur.vecAddr = 16'(VEC_IRQ - {11'h0, (anyMask ? winIdx : cur_ff.entryIdx), 1'b0});
                    nxt_cur.lastSrc = {1'b0, (anyMask ? winIdx : cur_ff.entryIdx)};
                end
            end
            ST_PULL: begin
                nxt_cur.stkRd = 1'b1;
                nxt_cur.stkAddr = 16'(cur_ff.spBase + 16'(cur_ff.cnt) + 16'h0001);
                nxt_cur.pullValid = cur_ff.stkRd;
                nxt_cur.pullIdx = 4'(FRAME_LAST - cur_ff.cnt);
                nxt_cur.cnt = 4'(cur_ff.cnt + 4'h1);
                if (cur_ff.cnt == FRAME_LAST) begin
                    nxt_cur.state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!cur_ff.pullValid && !cur_ff.stkRd) begin
                    nxt_cur.state = ST_IDLE;
                end
            end
        endcase
        // Read data lags the read strobe by one cycle
        if (cur_ff.stkRd) begin
            nxt_cur.pullValid = 1'b1;
            nxt_cur.pullIdx = 4'(FRAME_LAST + 4'h1 - cur_ff.cnt);
        end
        if (cur_ff.pullValid) begin
            nxt_cur.rstValid = 1'b1;
            nxt_cur.rstSel = cur_ff.pullIdx;
            nxt_cur.rstData = stackRdData;
            if (cur_ff.pullIdx == FRAME_LAST) begin
                nxt_cur.maskI = stackRdData[CCR_I_BIT];
                nxt_cur.maskX = stackRdData[CCR_X_BIT];
            end
        end
        nxt_cur.busyFlag = (nxt_cur.state != ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nxt_cur_reset();
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    task automatic nxt_cur_reset();
        cur_ff <= '0;
        cur_ff.waitReq <= 1'b1;
        cur_ff.psel <= PSEL_RESET;
        cur_ff.maskI <= 1'b1;
        cur_ff.maskX <= 1'b1;
        cur_ff.state <= ST_IDLE;
        cur_ff.kind <= K_MASK;
    endtask : nxt_cur_reset

    assign avsReadData = cur_ff.rdData;
    assign avsWaitRequest = cur_ff.waitReq;
    assign stackAddr = cur_ff.stkAddr;
    assign stackWrData = cur_ff.stkData;
    assign stackWrite = cur_ff.stkWr;
    assign stackRead = cur_ff.stkRd;
    assign vectorAddr = cur_ff.vecAddr;
    assign vectorValid = cur_ff.vecValid;
    assign busy = cur_ff.busyFlag;
    assign globalIrqMask = cur_ff.maskI;
    assign nonmaskableMask = cur_ff.maskX;
    assign restoreValid = cur_ff.rstValid;
    assign restoreSel = cur_ff.rstSel;
    assign restoreData = cur_ff.rstData;
endmodule : irs_exception_unit

// *** hdl/irs_pkg.sv ***
// Constants and types shared by the exception entry unit
package irs_pkg;
    // Register byte offsets on the slave bus
    localparam logic [7:0] OFS_PRIO = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_FLAG = 8'h08;
    localparam logic [7:0] OFS_ENAB = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // priority_misc_control layout
    localparam int PSEL_LSB = 0;
    localparam int PSEL_W = 4;
    localparam int VIS_BIT = 4;
    localparam logic [3:0] PSEL_RESET = 4'h5;
    // Mask register layout
    localparam int MASK_I_BIT = 0;
    localparam int MASK_X_BIT = 1;
    // condition_code_reg bit positions
    localparam int CCR_X_BIT = 6;
    localparam int CCR_I_BIT = 4;
    // Maskable source indices, default priority order (0 is highest)
    localparam int NUM_SRC = 15;
    localparam logic [3:0] SRC_IRQ = 4'h0;
    localparam logic [3:0] SRC_RTI = 4'h1;
    localparam logic [3:0] SRC_IC1 = 4'h2;
    localparam logic [3:0] SRC_OC1 = 4'h5;
    localparam logic [3:0] SRC_IC4OC5 = 4'h9;
    localparam logic [3:0] SRC_TOF = 4'hA;
    localparam logic [3:0] SRC_PAOV = 4'hB;
    localparam logic [3:0] SRC_PAEDGE = 4'hC;
    localparam logic [3:0] SRC_SPI = 4'hD;
    localparam logic [3:0] SRC_SCI = 4'hE;
    // promote_select codes with special meaning
    localparam logic [3:0] PSEL_TOF = 4'h0;
    localparam logic [3:0] PSEL_PAOV = 4'h1;
    localparam logic [3:0] PSEL_PAEDGE = 4'h2;
    localparam logic [3:0] PSEL_SPI = 4'h3;
    localparam logic [3:0] PSEL_SCI = 4'h4;
    localparam logic [3:0] PSEL_RSVD = 4'h5;
    localparam logic [3:0] PSEL_IRQ = 4'h6;
    localparam logic [3:0] PSEL_RTI = 4'h7;
    localparam logic [3:0] PSEL_IC1 = 4'h8;
    localparam logic [3:0] PSEL_OC1 = 4'hB;
    localparam logic [3:0] PSEL_IC4OC5 = 4'hF;
    // Vector addresses
    localparam logic [15:0] VEC_IRQ = 16'hFFF2;
    localparam logic [15:0] VEC_NONMASKABLE_PIN = 16'hFFF4;
    localparam logic [15:0] VEC_SWI = 16'hFFF6;
    localparam logic [15:0] VEC_ILL = 16'hFFF8;
    // Stack frame
    localparam logic [3:0] FRAME_LAST = 4'h8;
    typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_VECTOR, ST_PULL, ST_DRAIN} irs_state_type;
    typedef enum logic [1:0] {K_MASK, K_NONMASKABLE_PIN, K_SWI, K_ILL} irs_kind_type;
endpackage : irs_pkg

// *** verification/irs_exception_unit_props.sv ***
// Port-level checks for the exception entry unit
`timescale 1ns/1ps
module irs_exception_unit_props
    import irs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic [15:0] stackAddr,
    input wire logic stackWrite,
    input wire logic stackRead,
    input wire logic [15:0] vectorAddr,
    input wire logic vectorValid,
    input wire logic busy,
    input wire logic globalIrqMask,
    input wire logic nonmaskableMask,
    input wire logic restoreValid,
    input wire logic [3:0] restoreSel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("bus request not answered after one wait cycle");
    chk_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("wait request low for more than one cycle");
    chk_push_nine: assert property ($rose(stackWrite) |-> ##1 stackWrite [*8] ##1 !stackWrite)
        else $error("push frame is not nine bytes");
    chk_push_down: assert property (stackWrite && $past(stackWrite) |-> stackAddr == $past(stackAddr) - 16'h1)
        else $error("push address not descending");
    chk_pull_up: assert property (stackRead && $past(stackRead) |-> stackAddr == $past(stackAddr) + 16'h1)
        else $error("pull address not ascending");
    chk_mask_hold: assert property (stackWrite |-> $stable(globalIrqMask) && $stable(nonmaskableMask))
        else $error("mask changed before frame was stacked");
    chk_mask_after: assert property ($fell(stackWrite) |-> ##[0:1] globalIrqMask)
        else $error("global mask not set after stacking");
    chk_vector_soon: assert property ($fell(stackWrite) |-> ##[0:1] vectorValid)
        else $error("vector not issued after stacking");
    chk_restore_first: assert property ($rose(restoreValid) |-> restoreSel == 4'h8)
        else $error("restore does not begin with condition codes");
    chk_restore_down: assert property (restoreValid && $past(restoreValid) |-> restoreSel == $past(restoreSel) - 4'h1)
        else $error("restore order broken");
    chk_xmask_rise: assert property ($rose(nonmaskableMask) |-> vectorAddr == VEC_NONMASKABLE_PIN || restoreValid || $past(restoreValid))
        else $error("nonmaskable mask set without cause");
    chk_idle_quiet: assert property (!busy |-> !stackWrite && !stackRead)
        else $error("stack access while idle");
endmodule : irs_exception_unit_props

// *** verification/irs_core_model.sv ***
// Stack memory on the core side of the exception unit
`timescale 1ns/1ps
module irs_core_model (
    input wire logic clk,
    input wire logic [15:0] stackAddr,
    input wire logic [7:0] stackWrData,
    input wire logic stackWrite,
    input wire logic stackRead,
    output logic [7:0] stackRdData
);
    logic [7:0] mem [0:65535];
    logic [7:0] rdReg = 8'hA5;
    assign stackRdData = rdReg;
    always @(posedge clk) begin
        if (stackWrite) begin
            mem[stackAddr] <= stackWrData;
        end
        // Unread cycles show a changing pattern
        rdReg <= stackRead ? mem[stackAddr] : ~rdReg;
    end
endmodule : irs_core_model

// *** verification/test_irs_exception_unit.sv ***
// Self-checking bench for the exception entry unit
`timescale 1ns/1ps
module test_irs_exception_unit;
    import irs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [14:1] eventSet = 14'h0;
    logic irqPinN = 1'b1;
    logic xirqPinN = 1'b1;
    logic instrBoundary = 1'b0;
    logic illegalOp = 1'b0;
    logic swiExec = 1'b0;
    logic rtiExec = 1'b0;
    logic [15:0] opAddr = 16'hC0DE;
    logic [15:0] pcIn = 16'h1234;
    logic [15:0] iyIn = 16'h5678;
    logic [15:0] ixIn = 16'h9ABC;
    logic [7:0] accAIn = 8'hDE;
    logic [7:0] accBIn = 8'hF0;
    logic [7:0] ccrIn = 8'hAF;
    logic [15:0] spIn = 16'h01FF;
    logic [31:0] avsReadData, rd;
    logic avsWaitRequest, stackWrite, stackRead, vectorValid, busy, globalIrqMask, nonmaskableMask, restoreValid;
    logic [15:0] stackAddr, vectorAddr;
    logic [7:0] stackWrData, stackRdData, restoreData;
    logic [3:0] restoreSel;
    logic [7:0] frame [0:8];
    int errCount = 0;
    int comparisons = 0;
    int cycles = 0;
    irs_exception_unit i_irs_exception_unit (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .eventSet(eventSet), .irqPinN(irqPinN), .xirqPinN(xirqPinN),
        .instrBoundary(instrBoundary), .illegalOp(illegalOp), .swiExec(swiExec), .rtiExec(rtiExec),
        .opAddr(opAddr), .pcIn(pcIn), .iyIn(iyIn), .ixIn(ixIn), .accAIn(accAIn), .accBIn(accBIn), .ccrIn(ccrIn),
        .spIn(spIn), .stackRdData(stackRdData), .stackAddr(stackAddr), .stackWrData(stackWrData),
        .stackWrite(stackWrite), .stackRead(stackRead), .vectorAddr(vectorAddr), .vectorValid(vectorValid),
        .busy(busy), .globalIrqMask(globalIrqMask), .nonmaskableMask(nonmaskableMask),
        .restoreValid(restoreValid), .restoreSel(restoreSel), .restoreData(restoreData));
    irs_core_model i_irs_core_model (.clk(clk), .stackAddr(stackAddr), .stackWrData(stackWrData),
        .stackWrite(stackWrite), .stackRead(stackRead), .stackRdData(stackRdData));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            results();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic busOp(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk);
        avsAddress <= adr;
        avsWriteData <= dat;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge clk);
        while (avsWaitRequest) @(posedge clk);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : busOp
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        busOp(1'b1, adr, dat);
    endtask : wr
    task automatic rdChk(input logic [7:0] adr, input logic [15:0] exp);
        busOp(1'b0, adr, 32'h0);
        check(rd[15:0], exp);
    endtask : rdChk
    task automatic pulse(input logic ill, input logic software_trap_instr, input logic rti);
        @(posedge clk);
        instrBoundary <= 1'b1;
        illegalOp <= ill;
        swiExec <= software_trap_instr;
        rtiExec <= rti;
        @(posedge clk);
        instrBoundary <= 1'b0;
        illegalOp <= 1'b0;
        swiExec <= 1'b0;
        rtiExec <= 1'b0;
    endtask : pulse
    task automatic entry(input logic ill, input logic software_trap_instr, input logic [15:0] vec, input logic expX);
        int n;
        logic [15:0] pc;
        @(negedge clk);
        pc = ill ? opAddr : pcIn;
        frame = '{pc[7:0], pc[15:8], iyIn[7:0], iyIn[15:8], ixIn[7:0], ixIn[15:8], accAIn, accBIn,
                  {ccrIn[7], nonmaskableMask, ccrIn[5], globalIrqMask, ccrIn[3:0]}};
        pulse(ill, software_trap_instr, 1'b0);
        for (n = 0; n < 40 && vectorValid !== 1'b1; n++) @(negedge clk);
        check(16'(vectorValid), 16'h1);
        check(vectorAddr, vec);
        check(16'(globalIrqMask), 16'h1);
        check(16'(nonmaskableMask), 16'(expX));
        for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 9; n++) check(16'(i_irs_core_model.mem[spIn - 16'(n)]), 16'(frame[n]));
    endtask : entry
    task automatic rti;
        int n;
        int k;
        @(posedge clk);
        spIn <= 16'h01F6;
        pulse(1'b0, 1'b0, 1'b1);
        k = 0;
        for (n = 0; n < 40 && k < 9; n++) begin
            @(negedge clk);
            if (restoreValid === 1'b1) begin
                check(16'(restoreSel), 16'(8 - k));
                check(16'(restoreData), 16'(frame[8 - k]));
                k++;
            end
        end
        check(16'(k), 16'h9);
        check({14'h0, nonmaskableMask, globalIrqMask}, {14'h0, frame[8][6], frame[8][4]});
        @(posedge clk);
        spIn <= 16'h01FF;
    endtask : rti
    initial begin
        int c;
        int src;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdChk(OFS_MASK, 16'h3);
        rdChk(OFS_PRIO, 16'(PSEL_RESET));
        rdChk(8'h20, 16'h0);
        wr(OFS_ENAB, 32'h7FFE);
        irqPinN <= 1'b0;
        eventSet <= 14'h3FFF;
        @(posedge clk);
        eventSet <= 14'h0;
        // Masked requests must not start service
        pulse(1'b0, 1'b0, 1'b0);
        repeat (3) @(negedge clk);
        check(16'(busy), 16'h0);
        wr(OFS_MASK, 32'h2);
        wr(OFS_PRIO, 32'hA);
        rdChk(OFS_PRIO, 16'(PSEL_RESET));
        wr(OFS_MASK, 32'h3);
        for (c = 0; c < 16; c++) begin
            src = c < 5 ? c + 10 : c < 7 ? 0 : c - 6;
            wr(OFS_PRIO, 32'(c));
            rdChk(OFS_PRIO, 16'(c));
            pcIn <= 16'h1200 + 16'(c);
            accBIn <= 8'(~c);
            wr(OFS_MASK, 32'h2);
            entry(1'b0, 1'b0, 16'hFFF2 - 16'(2 * src), 1'b1);
        end
        @(posedge clk);
        irqPinN <= 1'b1;
        wr(OFS_ENAB, 32'h7FFC);
        wr(OFS_PRIO, 32'h7);
        wr(OFS_MASK, 32'h2);
        entry(1'b0, 1'b0, 16'hFFEE, 1'b1);
        rti();
        busOp(1'b0, OFS_FLAG, 32'h0);
        check(16'(rd[14:1]), 16'h3FFF);
        wr(OFS_FLAG, 32'h4);
        busOp(1'b0, OFS_FLAG, 32'h0);
        check(16'(rd[14:1]), 16'h3FFD);
        wr(OFS_MASK, 32'h0);
        wr(OFS_MASK, 32'h3);
        rdChk(OFS_MASK, 16'h1);
        wr(OFS_MASK, 32'h0);
        entry(1'b0, 1'b0, 16'hFFEC, 1'b0);
        wr(OFS_MASK, 32'h0);
        xirqPinN <= 1'b0;
        entry(1'b0, 1'b0, VEC_NONMASKABLE_PIN, 1'b1);
        @(posedge clk);
        xirqPinN <= 1'b1;
        entry(1'b0, 1'b1, VEC_SWI, 1'b1);
        entry(1'b1, 1'b0, VEC_ILL, 1'b1);
        results();
    end
endmodule : test_irs_exception_unit
bind irs_exception_unit irs_exception_unit_props i_irs_exception_unit_props (.clk(clk), .rst(rst),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest), .stackAddr(stackAddr),
    .stackWrite(stackWrite), .stackRead(stackRead), .vectorAddr(vectorAddr), .vectorValid(vectorValid),
    .busy(busy), .globalIrqMask(globalIrqMask), .nonmaskableMask(nonmaskableMask),
    .restoreValid(restoreValid), .restoreSel(restoreSel));
